// ### tb/cfg_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module cfg_host_model (
    input wire logic clk,
    input wire logic cfg_ack,
    input wire logic [31:0] cfg_rdata,
    output logic cfg_req,
    output logic cfg_we,
    output logic [7:0] cfg_addr,
    output logic [3:0] cfg_be,
    output logic [31:0] cfg_wdata
);
    initial begin
        cfg_req = 1'b0;
        cfg_we = 1'b0;
        cfg_addr = 8'h00;
        cfg_be = 4'h0;
        cfg_wdata = 32'h0;
    end
    // request held past the falling edge that sees the answer, to the next rising edge; idle lines show
    // inverted data so a stale value can never pass for a real one
    task automatic access(input logic we, input logic [7:0] a, input logic [3:0] be,
                          input logic [31:0] wd, output logic [31:0] rd, output logic ok);
        int n;
        n = 0;
        ok = 1'b0;
        rd = 32'h0;
        @(posedge clk);
        #1;
        cfg_req = 1'b1;
        cfg_we = we;
        cfg_addr = a;
        cfg_be = be;
        cfg_wdata = wd;
        while (!ok && n < 4) begin
            @(negedge clk);
            n++;
            ok = (cfg_ack === 1'b1);
        end
        rd = cfg_rdata;
        @(posedge clk);
        #1;
        cfg_req = 1'b0;
        cfg_we = ~we;
        cfg_addr = ~a;
        cfg_be = ~be;
        cfg_wdata = ~wd;
    endtask
endmodule
`default_nettype wire

// ### tb/cfg_status_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module cfg_status_asserts (
    input wire logic clk,
    input wire logic rst,
    input wire logic cfg_req,
    input wire logic cfg_we,
    input wire logic [7:0] cfg_addr,
    input wire logic [3:0] cfg_be,
    input wire logic [31:0] cfg_wdata,
    input wire logic [31:0] cfg_rdata,
    input wire logic cfg_ack,
    input wire logic system_error_request,
    input wire logic serr_n_out,
    input wire logic serr_n_oe,
    input wire logic parity_response_enable,
    input wire logic system_error_enable
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic take;
    logic rd_stat;
    logic rd_cls;
    logic wr_cmd;
    assign take = cfg_req && !cfg_ack;
    assign rd_stat = take && !cfg_we && cfg_addr[7:2] == 6'h01;
    assign rd_cls = take && !cfg_we && cfg_addr[7:2] == 6'h02;
    assign wr_cmd = take && cfg_we && cfg_addr[7:2] == 6'h01;
    // ****
    // access answers and read data
    // ****
    chk_ack_taken: assert property (take |=> cfg_ack)
        else $error("request not answered");
    chk_ack_single: assert property (cfg_ack |=> !cfg_ack)
        else $error("answer longer than one cycle");
    chk_devsel_field: assert property (cfg_ack && $past(rd_stat) |-> cfg_rdata[26:25] == 2'h1)
        else $error("select timing field wrong");
    chk_status_fixed: assert property (cfg_ack && $past(rd_stat) |->
        cfg_rdata[23:16] == 8'h10)
        else $error("fixed status bits wrong");
    chk_class_value: assert property (cfg_ack && $past(rd_cls) |->
        cfg_rdata == {8'h0c, 8'h00, 8'h10, cfg_status_pkg::silicon_revision_default})
        else $error("class register wrong");
    // ****
    // command bits and system error pin
    // ****
    chk_parity_response_enable_write: assert property (wr_cmd && cfg_be[0] |=>
        parity_response_enable == $past(cfg_wdata[6]))
        else $error("parity response enable not written");
    chk_serr_en_write: assert property (wr_cmd && cfg_be[1] |=> system_error_enable == $past(cfg_wdata[8]))
        else $error("system error enable not written");
    chk_serr_gated: assert property (serr_n_oe |->
        $past(system_error_enable) && $past(system_error_request))
        else $error("error pin driven while disabled");
    chk_serr_follow: assert property (system_error_request && system_error_enable |=>
        serr_n_oe && !serr_n_out)
        else $error("error pin not driven low");
endmodule
bind cfg_status_regs cfg_status_asserts chk_u (
    .clk(clk),
    .rst(rst),
    .cfg_req(cfg_req),
    .cfg_we(cfg_we),
    .cfg_addr(cfg_addr),
    .cfg_be(cfg_be),
    .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata),
    .cfg_ack(cfg_ack),
    .system_error_request(system_error_request),
    .serr_n_out(serr_n_out),
    .serr_n_oe(serr_n_oe),
    .parity_response_enable(parity_response_enable),
    .system_error_enable(system_error_enable)
);
`default_nettype wire

// ### tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk, rst, cfg_req, cfg_we, cfg_ack, serr_n_out, serr_n_oe, pe_out, se_out;
    logic [7:0] cfg_addr, ev;
    logic [3:0] cfg_be;
    logic [31:0] cfg_wdata, cfg_rdata, cls;
    logic [15:0] m_flags;
    logic m_pe, m_se;
    int bad_count, comparisons;
    cfg_host_model host_u (.clk(clk), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata), .cfg_req(cfg_req),
        .cfg_we(cfg_we), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata));
    cfg_status_regs dut_u (.clk(clk), .rst(rst), .cfg_req(cfg_req), .cfg_we(cfg_we),
        .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
        .cfg_ack(cfg_ack), .address_parity_error(ev[0]), .data_parity_error(ev[1]),
        .master_abort_seen(ev[2]), .target_abort_seen(ev[3]), .target_abort_signaled(ev[4]),
        .bus_master_active(ev[5]), .system_error_request(ev[6]), .perr_n_pin(~ev[7]),
        .serr_n_out(serr_n_out), .serr_n_oe(serr_n_oe), .parity_response_enable(pe_out),
        .system_error_enable(se_out));
    // ****
    // checking and model
    // ****
    task automatic test_done();
        if (bad_count == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    function automatic logic [31:0] dw1();
        return {m_flags | 16'h0210, 7'h0, m_se, 1'b0, m_pe, 6'h0};
    endfunction
    task automatic read_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] rd;
        logic ok;
        host_u.access(1'b0, a, 4'hf, 32'h0, rd, ok);
        check({31'h0, ok}, 32'h1);
        check(rd, exp);
    endtask
    task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] wd);
        logic [31:0] rd;
        logic ok;
        host_u.access(1'b1, a, be, wd, rd, ok);
        check({31'h0, ok}, 32'h1);
        if (a[7:2] == 6'h01) begin
            if (be[0]) m_pe = wd[6];
            if (be[1]) m_se = wd[8];
            if (be[2]) m_flags[7:0] = m_flags[7:0] & ~wd[23:16];
            if (be[3]) m_flags[15:8] = m_flags[15:8] & ~wd[31:24];
        end
        check({30'h0, se_out, pe_out}, {30'h0, m_se, m_pe});
    endtask
    // events held six cycles so the filtered error pin overlaps the master flag
    task automatic events(input logic [7:0] v);
        ev = v;
        repeat (6) @(posedge clk);
        #1;
        check({31'h0, serr_n_oe}, {31'h0, v[6] & m_se});
        if (v[0] | v[1]) m_flags[15] = 1'b1;
        if (v[6] & m_se) m_flags[14] = 1'b1;
        if (v[2] & v[5]) m_flags[13] = 1'b1;
        if (v[3] & v[5]) m_flags[12] = 1'b1;
        if (v[4]) m_flags[11] = 1'b1;
        if (v[7] & v[5] & m_pe) m_flags[8] = 1'b1;
        ev = 8'h00;
        repeat (6) @(posedge clk);
        #1;
    endtask
    // ****
    // stimulus
    // ****
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        test_done();
    end
    initial begin
        rst = 1'b1;
        ev = 8'h00;
        bad_count = 0;
        comparisons = 0;
        m_flags = 16'h0;
        m_pe = 1'b0;
        m_se = 1'b0;
        cls = {8'h0c, 8'h00, 8'h10, cfg_status_pkg::silicon_revision_default};
        void'($urandom(44611));
        repeat (20) @(posedge clk);
        #1;
        rst = 1'b0;
        read_chk(8'h06, 32'h0210_0000);
        read_chk(8'h08, cls);
        wr(8'h08, 4'hf, 32'hffff_ffff);
        read_chk(8'h08, cls);
        read_chk(8'h40, 32'h0);
        wr(8'h04, 4'h3, 32'h0000_0140);
        for (int i = 0; i < 8; i++) begin
            events(8'h20 | (8'h01 << i));
            read_chk(8'h06, dw1());
            wr(8'h06, 4'hc, 32'h0000_0000);
            read_chk(8'h06, dw1());
            wr(8'h06, 4'hf, 32'hffff_0140);
            read_chk(8'h04, dw1());
        end
        // event and clear at the same taking edge: the event must win
        fork
            wr(8'h06, 4'hc, 32'hffff_0000);
            begin
                @(posedge clk);
                #1;
                ev = 8'h10;
                @(posedge clk);
                #1;
                ev = 8'h00;
            end
        join
        m_flags[11] = 1'b1;
        read_chk(8'h06, dw1());
        // mid-run reset drops every flag and command bit
        events(8'hff);
        rst = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        rst = 1'b0;
        m_flags = 16'h0;
        m_pe = 1'b0;
        m_se = 1'b0;
        read_chk(8'h06, 32'h0210_0000);
        for (int i = 0; i < 40; i++) begin
            events(8'($urandom()));
            read_chk(8'h06, dw1());
            wr(($urandom() % 2) ? 8'h04 : 8'h06, 4'($urandom()), 32'($urandom()));
            read_chk(8'h06, dw1());
        end
        test_done();
    end
endmodule
`default_nettype wire

// ### verilog/cfg_status_pkg.sv
// Behaviour
// - set status bit 15 on any address or data parity error detected.
// - set status bit 14 when system error reported while its enable is one.
// - set status bit 13 when own master cycle ends in master abort.
// - set status bit 12 when own master cycle ends in target abort.
// - set status bit 11 when device as target signals target abort.
// - status bits 10 to 9 read fixed 01b, medium select timing.
// - set bit 8 only on bus error, device master, parity response enabled.
// - status bit 7 reads zero, no fast back-to-back as target.
// - status bit 6 reads zero, no user-definable features.
// - status bit 5 reads zero, bus clock limited to 33 MHz.
// - status bit 4 reads one, capabilities list is present.
// - reserved status bits 3 to 0 always read zero.
// - status register at offset 06h, 16 bits, reset value 0210h.
// - class register bits 31 to 24 read 0Ch, serial bus controller.
// - class register bits 23 to 16 read zero subclass.
// - class register bits 15 to 8 read 10h programming interface.
// - class register bits 7 to 0 hold fixed silicon revision code, offset 08h.
// - system error pin driven only one clock after a request seen while command bit 8 is one.
`default_nettype none
package cfg_status_pkg;

    // ********************************************************************
    // configuration offsets (byte addresses)
    // ********************************************************************
    localparam logic [7:0] command_off = 8'h04;
    localparam logic [7:0] bus_status_off = 8'h06;
    localparam logic [7:0] class_off = 8'h08;

    // ********************************************************************
    // status field positions
    // ********************************************************************
    localparam int detected_parity_bit = 15;
    localparam int signaled_system_error_bit = 14;
    localparam int received_master_abort_bit = 13;
    localparam int received_target_abort_bit = 12;
    localparam int signaled_target_abort_bit = 11;
    localparam int devsel_timing_lsb = 9;
    localparam int master_data_parity_bit = 8;
    localparam int back_to_back_capable_bit = 7;
    localparam int user_features_supported_bit = 6;
    localparam int high_speed_capable_bit = 5;
    localparam int capability_list_present_bit = 4;

    localparam logic [1:0] devsel_medium = 2'h1;
    localparam logic [15:0] bus_status_reset = 16'h0210;

    // ********************************************************************
    // command bits kept here
    // ********************************************************************
    localparam int parity_response_enable_bit = 6;
    localparam int system_error_enable_bit = 8;
    localparam logic [15:0] command_reset = 16'h0000;

    // ********************************************************************
    // class code fields
    // ********************************************************************
    localparam logic [7:0] base_class_code = 8'h0c;
    localparam logic [7:0] sub_class_code = 8'h00;
    localparam logic [7:0] programming_interface_code = 8'h10;
    // arbitrary value, replace per silicon step
    localparam logic [7:0] silicon_revision_default = 8'h5a;

    typedef enum logic [0:0] {
        acc_idle,
        acc_answer
    } access_state_e;

endpackage
`default_nettype wire

// ### verilog/cfg_status_regs.sv
`timescale 1ns/1ps
`default_nettype none
module cfg_status_regs (
    input wire logic clk,
    input wire logic rst,
    // configuration access port
    input wire logic cfg_req,
    input wire logic cfg_we,
    input wire logic [7:0] cfg_addr,
    input wire logic [3:0] cfg_be,
    input wire logic [31:0] cfg_wdata,
    output logic [31:0] cfg_rdata,
    output logic cfg_ack,
    // events from the master and target engines
    input wire logic address_parity_error,
    input wire logic data_parity_error,
    input wire logic master_abort_seen,
    input wire logic target_abort_seen,
    input wire logic target_abort_signaled,
    input wire logic bus_master_active,
    input wire logic system_error_request,
    // bus pins
    input wire logic perr_n_pin,
    output logic serr_n_out,
    output logic serr_n_oe,
    // command bits other logic depends on
    output logic parity_response_enable,
    output logic system_error_enable
);

    // limitations: only command bits 6 and 8 live here, the rest of that
    // register belongs elsewhere; the event inputs must already be on clk,
    // only the bus error pin is filtered here

    // ********************************************************************
    // functions
    // ********************************************************************

    // set always wins over a clear in the same cycle
    function automatic logic sticky_next(
        input logic cur,
        input logic set_ev,
        input logic clr
    );
        sticky_next = set_ev | (cur & ~clr);
    endfunction

    // true when the access hits the dword holding the given byte offset
    function automatic logic dword_hit(
        input logic [7:0] addr,
        input logic [7:0] off
    );
        dword_hit = (addr[7:2] == off[7:2]);
    endfunction

    // ********************************************************************
    // declarations
    // ********************************************************************
    cfg_status_pkg::access_state_e acc_state_ff;
    cfg_status_pkg::access_state_e nxt_acc_state;

    logic [31:0] cfg_rdata_ff;
    logic [31:0] nxt_cfg_rdata;
    logic cfg_ack_ff;
    logic nxt_cfg_ack;

    logic detected_parity_flag_ff;
    logic signaled_system_error_flag_ff;
    logic received_master_abort_flag_ff;
    logic received_target_abort_flag_ff;
    logic signaled_target_abort_flag_ff;
    logic master_data_parity_flag_ff;
    logic nxt_detected_parity_flag;
    logic nxt_signaled_system_error_flag;
    logic nxt_received_master_abort_flag;
    logic nxt_received_target_abort_flag;
    logic nxt_signaled_target_abort_flag;
    logic nxt_master_data_parity_flag;

    logic parity_response_enable_ff;
    logic system_error_enable_ff;
    logic nxt_parity_response_enable;
    logic nxt_system_error_enable;

    logic serr_oe_ff;
    logic nxt_serr_oe;

    logic parity_seen;
    logic system_error_seen;
    logic master_abort_hit;
    logic target_abort_hit;
    logic target_abort_sent;
    logic master_parity_hit;

    logic [7:0] silicon_revision_code;
    logic perr_level_n;
    logic status_write;
    logic command_write;
    logic [15:0] status_clear;
    logic [15:0] bus_status_view;
    logic [15:0] command_view;
    logic [31:0] class_view;

    // ********************************************************************
    // bus error pin
    // ********************************************************************
    // the pin is asynchronous to clk and idles high, so it is filtered first
    pin_filter perr_filter (
        .clk(clk),
        .rst(rst),
        .pin(perr_n_pin),
        .level(perr_level_n)
    );

    // ********************************************************************
    // write decode
    // ********************************************************************
    // both halves of dword 1 decode alike; the byte enables pick the half
    assign status_write = cfg_req & cfg_we & (acc_state_ff == cfg_status_pkg::acc_idle)
        & dword_hit(cfg_addr, cfg_status_pkg::bus_status_off);
    assign command_write = cfg_req & cfg_we & (acc_state_ff == cfg_status_pkg::acc_idle)
        & dword_hit(cfg_addr, cfg_status_pkg::command_off);

    // status lives in the upper half of the dword; only enabled lanes clear
    // a zero in an enabled lane leaves its flag alone
    always_comb begin
        status_clear = 16'h0000;
        if (status_write) begin
            if (cfg_be[2]) begin
                status_clear[7:0] = cfg_wdata[23:16];
            end
            if (cfg_be[3]) begin
                status_clear[15:8] = cfg_wdata[31:24];
            end
        end
    end

    // ********************************************************************
    // command bits
    // ********************************************************************
    // only bits 6 and 8 are kept; every other command bit reads zero
    always_comb begin
        nxt_parity_response_enable = parity_response_enable_ff;
        nxt_system_error_enable = system_error_enable_ff;
        if (command_write && cfg_be[0]) begin
            nxt_parity_response_enable = cfg_wdata[cfg_status_pkg::parity_response_enable_bit];
        end
        if (command_write && cfg_be[1]) begin
            nxt_system_error_enable = cfg_wdata[cfg_status_pkg::system_error_enable_bit];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            parity_response_enable_ff <= cfg_status_pkg::command_reset[cfg_status_pkg::parity_response_enable_bit];
            system_error_enable_ff <= cfg_status_pkg::command_reset[cfg_status_pkg::system_error_enable_bit];
        end else begin
            parity_response_enable_ff <= nxt_parity_response_enable;
            system_error_enable_ff <= nxt_system_error_enable;
        end
    end

    // ********************************************************************
    // system error pin
    // ********************************************************************
    // open-drain: the pin is only ever pulled low, never driven high
    always_comb begin
        nxt_serr_oe = system_error_request & system_error_enable_ff;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            serr_oe_ff <= 1'b0;
        end else begin
            serr_oe_ff <= nxt_serr_oe;
        end
    end

    // ********************************************************************
    // set events
    // ********************************************************************
    // received aborts only count for cycles this device started itself
    always_comb begin
        parity_seen = address_parity_error | data_parity_error;

        // flagged when the pin is really pulled, not on the request
        system_error_seen = serr_oe_ff;

        master_abort_hit = master_abort_seen & bus_master_active;
        target_abort_hit = target_abort_seen & bus_master_active;
        target_abort_sent = target_abort_signaled;

        // the filtered pin lags the bus by four clocks; bus_master_active
        // must be held by the master engine across that window, or a late
        // error report is lost
        master_parity_hit = ~perr_level_n & bus_master_active & parity_response_enable_ff;
    end

    // ********************************************************************
    // sticky error flags
    // ********************************************************************
    always_comb begin
        nxt_detected_parity_flag = sticky_next(detected_parity_flag_ff,
            parity_seen,
            status_clear[cfg_status_pkg::detected_parity_bit]);

        nxt_signaled_system_error_flag = sticky_next(signaled_system_error_flag_ff,
            system_error_seen,
            status_clear[cfg_status_pkg::signaled_system_error_bit]);

        nxt_received_master_abort_flag = sticky_next(received_master_abort_flag_ff,
            master_abort_hit,
            status_clear[cfg_status_pkg::received_master_abort_bit]);

        nxt_received_target_abort_flag = sticky_next(received_target_abort_flag_ff,
            target_abort_hit,
            status_clear[cfg_status_pkg::received_target_abort_bit]);

        nxt_signaled_target_abort_flag = sticky_next(signaled_target_abort_flag_ff,
            target_abort_sent,
            status_clear[cfg_status_pkg::signaled_target_abort_bit]);

        nxt_master_data_parity_flag = sticky_next(master_data_parity_flag_ff,
            master_parity_hit,
            status_clear[cfg_status_pkg::master_data_parity_bit]);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            detected_parity_flag_ff <= cfg_status_pkg::bus_status_reset[cfg_status_pkg::detected_parity_bit];
            signaled_system_error_flag_ff <=
                cfg_status_pkg::bus_status_reset[cfg_status_pkg::signaled_system_error_bit];
            received_master_abort_flag_ff <=
                cfg_status_pkg::bus_status_reset[cfg_status_pkg::received_master_abort_bit];
            received_target_abort_flag_ff <=
                cfg_status_pkg::bus_status_reset[cfg_status_pkg::received_target_abort_bit];
            signaled_target_abort_flag_ff <=
                cfg_status_pkg::bus_status_reset[cfg_status_pkg::signaled_target_abort_bit];
            master_data_parity_flag_ff <=
                cfg_status_pkg::bus_status_reset[cfg_status_pkg::master_data_parity_bit];
        end else begin
            detected_parity_flag_ff <= nxt_detected_parity_flag;
            signaled_system_error_flag_ff <= nxt_signaled_system_error_flag;
            received_master_abort_flag_ff <= nxt_received_master_abort_flag;
            received_target_abort_flag_ff <= nxt_received_target_abort_flag;
            signaled_target_abort_flag_ff <= nxt_signaled_target_abort_flag;
            master_data_parity_flag_ff <= nxt_master_data_parity_flag;
        end
    end

    // ********************************************************************
    // read views
    // ********************************************************************
    assign silicon_revision_code = cfg_status_pkg::silicon_revision_default;

    // reserved and hardwired bits come from constants, never from flops
    always_comb begin
        bus_status_view = 16'h0000;
        bus_status_view[cfg_status_pkg::detected_parity_bit] = detected_parity_flag_ff;
        bus_status_view[cfg_status_pkg::signaled_system_error_bit] = signaled_system_error_flag_ff;
        bus_status_view[cfg_status_pkg::received_master_abort_bit] = received_master_abort_flag_ff;
        bus_status_view[cfg_status_pkg::received_target_abort_bit] = received_target_abort_flag_ff;
        bus_status_view[cfg_status_pkg::signaled_target_abort_bit] = signaled_target_abort_flag_ff;
        bus_status_view[cfg_status_pkg::devsel_timing_lsb +: 2] = cfg_status_pkg::devsel_medium;
        bus_status_view[cfg_status_pkg::master_data_parity_bit] = master_data_parity_flag_ff;
        bus_status_view[cfg_status_pkg::back_to_back_capable_bit] = 1'b0;
        bus_status_view[cfg_status_pkg::user_features_supported_bit] = 1'b0;
        bus_status_view[cfg_status_pkg::high_speed_capable_bit] = 1'b0;
        bus_status_view[cfg_status_pkg::capability_list_present_bit] = 1'b1;
    end

    always_comb begin
        command_view = 16'h0000;
        command_view[cfg_status_pkg::parity_response_enable_bit] = parity_response_enable_ff;
        command_view[cfg_status_pkg::system_error_enable_bit] = system_error_enable_ff;
    end

    // every class field is hardwired; writes to this dword are dropped
    assign class_view = {cfg_status_pkg::base_class_code,
        cfg_status_pkg::sub_class_code,
        cfg_status_pkg::programming_interface_code,
        silicon_revision_code};

    // ********************************************************************
    // access sequencer
    // ********************************************************************
    // one answer per request; a request during the answer cycle is ignored
    // read data is captured at the taking edge, so a flag set in the
    // answer cycle shows on the next read, never half-way through one
    always_comb begin
        nxt_acc_state = acc_state_ff;
        nxt_cfg_ack = 1'b0;
        nxt_cfg_rdata = cfg_rdata_ff;
        case (acc_state_ff)
            cfg_status_pkg::acc_idle: begin
                if (cfg_req) begin
                    nxt_acc_state = cfg_status_pkg::acc_answer;
                    nxt_cfg_ack = 1'b1;
                    nxt_cfg_rdata = 32'h0000_0000;
                    if (!cfg_we) begin
                        // status shares its dword with the command half
                        if (dword_hit(cfg_addr, cfg_status_pkg::bus_status_off)) begin
                            nxt_cfg_rdata = {bus_status_view, command_view};
                        end else if (dword_hit(cfg_addr, cfg_status_pkg::class_off)) begin
                            nxt_cfg_rdata = class_view;
                        end
                    end
                end
            end
            cfg_status_pkg::acc_answer: begin
                nxt_acc_state = cfg_status_pkg::acc_idle;
            end
            default: begin
                nxt_acc_state = cfg_status_pkg::acc_idle;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            acc_state_ff <= cfg_status_pkg::acc_idle;
            cfg_ack_ff <= 1'b0;
            cfg_rdata_ff <= 32'h0000_0000;
        end else begin
            acc_state_ff <= nxt_acc_state;
            cfg_ack_ff <= nxt_cfg_ack;
            cfg_rdata_ff <= nxt_cfg_rdata;
        end
    end

    // ********************************************************************
    // outputs
    // ********************************************************************
    // command bits leave as registered copies so no other logic loads the decode
    assign cfg_rdata = cfg_rdata_ff;
    assign cfg_ack = cfg_ack_ff;
    assign serr_n_oe = serr_oe_ff;
    assign serr_n_out = 1'b0;
    assign parity_response_enable = parity_response_enable_ff;
    assign system_error_enable = system_error_enable_ff;

endmodule
`default_nettype wire

// ### verilog/pin_filter.sv
`timescale 1ns/1ps
`default_nettype none
module pin_filter (
    input wire logic clk,
    input wire logic rst,
    input wire logic pin,
    output logic level
);

    logic s1_ff;
    logic s2_ff;
    logic s3_ff;
    logic level_ff;
    logic nxt_level;

    // pin is idle high, so every stage resets high
    always_comb begin
        nxt_level = level_ff;
        if (s2_ff == s3_ff) begin
            nxt_level = s3_ff;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_ff <= 1'b1;
            s2_ff <= 1'b1;
            s3_ff <= 1'b1;
            level_ff <= 1'b1;
        end else begin
            s1_ff <= pin;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            level_ff <= nxt_level;
        end
    end

    assign level = level_ff;

endmodule
`default_nettype wire
